// file: adcc_pkg.sv
package adcc_pkg;

  localparam int ADDR_W = 8;
  localparam int NCH    = 6;

  // printed offsets are word indices; byte address is index times four
  localparam logic [5:0] IDX_MODE  = 6'h02;
  localparam logic [5:0] IDX_CLOCK = 6'h03;
  localparam logic [5:0] IDX_GAIN  = 6'h04;
  localparam logic [5:0] IDX_STAT  = 6'h08;
  localparam logic [5:0] IDX_MASK  = 6'h09;

  localparam logic [15:0] MODE_RST   = 16'h0510;
  localparam logic [15:0] CLOCK_RST  = 16'h7F0E;
  localparam logic [15:0] GAIN_RST   = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h3FFF;
  localparam logic [15:0] CLK_WMASK  = 16'h3FFF;
  localparam logic [15:0] GAIN_WMASK = 16'hFFFF;

  localparam int MODE_SEL_LSB = 2;
  localparam int MODE_HIZ_BIT = 1;
  localparam int MODE_FMT_BIT = 0;
  localparam int CLK_EN_LSB   = 8;
  localparam int CLK_XTAL_BIT = 7;
  localparam int CLK_REF_BIT  = 6;
  localparam int CLK_OSR_LSB  = 2;
  localparam int CLK_PWR_LSB  = 0;
  localparam int GAIN_STRIDE  = 4;

  localparam logic [1:0]  SRC_LAG  = 2'h0;
  localparam logic [1:0]  SRC_OR   = 2'h1;
  localparam logic [14:0] OSR_BASE = 15'h0080;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  localparam int CLK_MHZ   = 125;
  localparam int PULSE_NS  = 32;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {PWR_VLP, PWR_LP, PWR_HR} adcc_pwr_t;

  typedef struct packed {
    logic [5:0]      chan_enable;
    logic            crystal_osc_off;
    logic            external_reference_on;
    logic [2:0]      oversampling_ratio;
    logic [14:0]     osr_value;
    logic [1:0]      power_mode_select;
    adcc_pwr_t       power_mode;
    logic [3:0][2:0] chan_gain_code;
    logic [1:0]      ready_source_select;
    logic            ready_idle_tristate;
    logic            ready_pulse_format;
  } adcc_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } adcc_pin_t;

  function automatic logic [15:0] adcc_merge(input logic [15:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] v;
    v = old_v;
    if (strb[0]) v[7:0] = new_v[7:0];
    if (strb[1]) v[15:8] = new_v[15:8];
    return v & wmask;
  endfunction : adcc_merge

endpackage : adcc_pkg

// file: adcc_axil_slave.sv
`timescale 1ns/100ps
module adcc_axil_slave
  import adcc_pkg::*;
(
  input  wire logic              sys_clk_in,      // system clock
  input  wire logic              rst_in,          // sync reset
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in, // write address
  input  wire logic              s_axi_awvalid_in,// write address valid
  output logic                   s_axi_awready_out,// write address ready
  input  wire logic [31:0]       s_axi_wdata_in,  // write data
  input  wire logic [3:0]        s_axi_wstrb_in,  // byte strobes
  input  wire logic              s_axi_wvalid_in, // write data valid
  output logic                   s_axi_wready_out,// write data ready
  output logic [1:0]             s_axi_bresp_out, // write response
  output logic                   s_axi_bvalid_out,// response valid
  input  wire logic              s_axi_bready_in, // response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in, // read address
  input  wire logic              s_axi_arvalid_in,// read address valid
  output logic                   s_axi_arready_out,// read address ready
  output logic [31:0]            s_axi_rdata_out, // read data
  output logic [1:0]             s_axi_rresp_out, // read response
  output logic                   s_axi_rvalid_out,// read valid
  input  wire logic              s_axi_rready_in, // read ready
  output logic                   wr_req_out,      // register write pulse
  output logic [5:0]             wr_idx_out,      // write word index
  output logic [31:0]            wr_data_out,     // write data
  output logic [3:0]             wr_strb_out,     // write strobes
  input  wire logic              wr_ok_in,        // index is mapped
  output logic                   rd_req_out,      // register read pulse
  output logic [5:0]             rd_idx_out,      // read word index
  input  wire logic [31:0]       rd_data_in,      // read data
  input  wire logic              rd_ok_in         // index is mapped
);

  logic [5:0]  aw_idx_reg, aw_idx_next;
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        arready_reg, arready_next;

  assign wr_req_out  = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_idx_out  = aw_idx_reg;
  assign wr_data_out = w_data_reg;
  assign wr_strb_out = w_strb_reg;
  assign rd_req_out  = s_axi_arvalid_in & arready_reg;
  assign rd_idx_out  = s_axi_araddr_in[7:2];

  always_comb begin
    aw_idx_next  = aw_idx_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid_in && awready_reg) begin
      aw_idx_next  = s_axi_awaddr_in[7:2];
      aw_full_next = 1'b1;
    end
    if (s_axi_wvalid_in && wready_reg) begin
      w_data_next = s_axi_wdata_in;
      w_strb_next = s_axi_wstrb_in;
      w_full_next = 1'b1;
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
    if (wr_req_out) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_ok_in ? RESP_OK : RESP_ERR;
    end
    if (rvalid_reg && s_axi_rready_in) begin
      rvalid_next = 1'b0;
    end
    if (rd_req_out) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_ok_in ? rd_data_in : 32'h0000_0000;
      rresp_next  = rd_ok_in ? RESP_OK : RESP_ERR;
    end
    // one write and one read outstanding at a time
    awready_next = ~aw_full_next & ~bvalid_next;
    wready_next  = ~w_full_next & ~bvalid_next;
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aw_idx_reg  <= 6'h00;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OK;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      aw_idx_reg  <= aw_idx_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out  = wready_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;

endmodule : adcc_axil_slave

// file: adcc_ready_pin.sv
`timescale 1ns/100ps
module adcc_ready_pin
  import adcc_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYC
) (
  input  wire logic sys_clk_in, // system clock
  input  wire logic rst_in,     // sync reset
  input  wire logic trig_in,    // selected source has data
  input  wire logic clr_in,     // host took the data
  input  wire logic hiz_in,     // float when idle
  input  wire logic fmt_in,     // pulse instead of level
  output adcc_pin_t pin_out     // pin drive and enable
);

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_PULSE, ST_SPENT} adcc_rdy_st_t;

  adcc_rdy_st_t st_reg, st_next;
  logic [7:0]   cnt_reg, cnt_next;
  adcc_pin_t    pin_reg, pin_next;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    // new data wins over a clear in the same cycle
    if (trig_in) begin
      st_next  = fmt_in ? ST_PULSE : ST_HOLD;
      cnt_next = 8'(PULSE_LEN - 1);
    end else if (clr_in) begin
      st_next = ST_IDLE;
    end else begin
      case (st_reg)
        ST_PULSE: begin
          if (cnt_reg == 8'h00) st_next = ST_SPENT;
          else cnt_next = cnt_reg - 8'h01;
        end
        default: begin
        end
      endcase
    end
    case (st_next)
      ST_HOLD, ST_PULSE: pin_next = '{o: 1'b0, oe: 1'b1};
      default:           pin_next = '{o: 1'b1, oe: ~hiz_in};
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_reg  <= ST_IDLE;
      cnt_reg <= 8'h00;
      pin_reg <= '{o: 1'b1, oe: 1'b1};
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
    end
  end

  assign pin_out = pin_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  idle_high_a: assert property ((st_reg == ST_IDLE && !$past(hiz_in)) |-> pin_out.o && pin_out.oe)
    else $error("idle pin not driven high");
  idle_float_a: assert property ((st_reg == ST_SPENT && $past(hiz_in)) |-> !pin_out.oe)
    else $error("idle pin not released");
  level_low_a: assert property ((trig_in && !fmt_in) ##1 !clr_in |-> !pin_out.o && pin_out.oe)
    else $error("level low missing");
  pulse_len_a: assert property ((trig_in && fmt_in) ##1 (!trig_in && !clr_in) [*4] |-> ##1 pin_out.o)
    else $error("pulse length wrong");
  pulse_cv: cover property ((trig_in && fmt_in) ##1 !pin_out.o [*4] ##1 pin_out.o);
  float_cv: cover property (hiz_in ##2 !pin_out.oe);

endmodule : adcc_ready_pin

// file: adcc_cfg_regs.sv
`timescale 1ns/100ps
// What this block does
// - The ready source field picks most lagging (00, reset), OR of enabled (01) or most leading channel (10, 11).
// - With no data pending the ready pin is driven high if the idle bit is 0 and floats if it is 1.
// - On new data the ready pin is held low for format 0 or pulsed low for a fixed time for format 1.
// - The clock register sits at index 03h, is 16 bits and resets to 7F0Eh.
// - Clock bits 13..8 enable channels 5..0, all enabled after reset.
// - Clock bits 15..14 are read-only and read 00.
// - Clock bit 7 turns the crystal oscillator off when 1, reset 0.
// - Clock bit 6 turns the external reference on when 1, reset 0.
// - Clock bits 4..2 set oversampling to 128 shifted left by the code, reset 011.
// - Clock bits 1..0 pick very-low-power, low-power or high-resolution (10 and 11), reset 10.
// - The first gain register sits at index 04h, is 16 bits and resets to 0000h.
// - Gain bits 14..12 give channel 3 a gain of two to the code, reset 000.
// - Gain bits 10..8 give channel 2 the same encoding, reset 000.
// - Gain bits 6..4 give channel 1 the same encoding, reset 000.
// - Gain bits 2..0 give channel 0 the same encoding, reset 000.
module adcc_cfg_regs
  import adcc_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYC
) (
  input  wire logic              sys_clk_in,       // system clock, 125 MHz
  input  wire logic              rst_in,           // sync reset, active high
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,  // write address
  input  wire logic              s_axi_awvalid_in, // write address valid
  output logic                   s_axi_awready_out,// write address ready
  input  wire logic [31:0]       s_axi_wdata_in,   // write data
  input  wire logic [3:0]        s_axi_wstrb_in,   // byte strobes
  input  wire logic              s_axi_wvalid_in,  // write data valid
  output logic                   s_axi_wready_out, // write data ready
  output logic [1:0]             s_axi_bresp_out,  // write response
  output logic                   s_axi_bvalid_out, // response valid
  input  wire logic              s_axi_bready_in,  // response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,  // read address
  input  wire logic              s_axi_arvalid_in, // read address valid
  output logic                   s_axi_arready_out,// read address ready
  output logic [31:0]            s_axi_rdata_out,  // read data
  output logic [1:0]             s_axi_rresp_out,  // read response
  output logic                   s_axi_rvalid_out, // read valid
  input  wire logic              s_axi_rready_in,  // read ready
  input  wire logic [NCH-1:0]    chan_event_in,    // per-channel new data pulse
  input  wire logic              data_read_in,     // host took the data, pulse
  output adcc_cfg_t              cfg_out,          // decoded configuration
  output logic                   sample_ready_pin_out,    // ready pin level
  output logic                   sample_ready_pin_oe_out, // ready pin enable
  output logic                   irq_out           // interrupt, level
);

  logic        wr_req, rd_req, wr_ok, rd_ok, trig;
  logic [5:0]  wr_idx, rd_idx;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  logic [5:0]  en, ev, seen_keep;
  adcc_pin_t   pin;

  logic [15:0]    mode_reg, mode_next, clock_reg, clock_next, gain_reg, gain_next;
  logic [NCH-1:0] stat_reg, stat_next, mask_reg, mask_next, seen_reg, seen_next;
  adcc_cfg_t      cfg_reg, cfg_next;
  logic           irq_reg, irq_next;

  function automatic logic is_mapped(input logic [5:0] idx);
    return idx == IDX_MODE || idx == IDX_CLOCK || idx == IDX_GAIN ||
           idx == IDX_STAT || idx == IDX_MASK;
  endfunction : is_mapped

  adcc_axil_slave u_bus (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .wr_req_out        (wr_req),
    .wr_idx_out        (wr_idx),
    .wr_data_out       (wr_data),
    .wr_strb_out       (wr_strb),
    .wr_ok_in          (wr_ok),
    .rd_req_out        (rd_req),
    .rd_idx_out        (rd_idx),
    .rd_data_in        (rd_data),
    .rd_ok_in          (rd_ok)
  );

  assign wr_ok = is_mapped(wr_idx);
  assign rd_ok = is_mapped(rd_idx);

  always_comb begin
    case (rd_idx)
      IDX_MODE:  rd_data = {16'h0000, mode_reg};
      IDX_CLOCK: rd_data = {16'h0000, clock_reg & CLK_WMASK};
      IDX_GAIN:  rd_data = {16'h0000, gain_reg};
      IDX_STAT:  rd_data = {26'h0000000, stat_reg};
      IDX_MASK:  rd_data = {26'h0000000, mask_reg};
      default:   rd_data = 32'h0000_0000;
    endcase
  end

  assign en = cfg_reg.chan_enable;
  assign ev = chan_event_in & en;
  assign seen_keep = data_read_in ? 6'h00 : seen_reg;

  always_comb begin
    case (cfg_reg.ready_source_select)
      SRC_LAG: trig = (|ev) && (((seen_keep | ev) | ~en) == 6'h3F);
      SRC_OR:  trig = |ev;
      default: trig = (|ev) && !(|(seen_keep & en));
    endcase
  end

  always_comb begin
    mode_next  = mode_reg;
    clock_next = clock_reg;
    gain_next  = gain_reg;
    mask_next  = mask_reg;
    seen_next  = seen_keep | ev;
    stat_next  = stat_reg;
    if (wr_req) begin
      case (wr_idx)
        IDX_MODE:  mode_next = adcc_merge(mode_reg, wr_data, wr_strb, MODE_WMASK);
        IDX_CLOCK: clock_next = adcc_merge(clock_reg, wr_data, wr_strb, CLK_WMASK);
        IDX_GAIN:  gain_next = adcc_merge(gain_reg, wr_data, wr_strb, GAIN_WMASK);
        IDX_MASK:  mask_next = wr_strb[0] ? wr_data[5:0] : mask_reg;
        default: begin
        end
      endcase
    end
    // read clears status; a new event in the same cycle survives
    if (rd_req && rd_idx == IDX_STAT) stat_next = 6'h00;
    stat_next = stat_next | ev;
    irq_next  = |(stat_next & mask_next);
    cfg_next.chan_enable           = clock_next[CLK_EN_LSB +: NCH];
    cfg_next.crystal_osc_off       = clock_next[CLK_XTAL_BIT];
    cfg_next.external_reference_on = clock_next[CLK_REF_BIT];
    cfg_next.oversampling_ratio    = clock_next[CLK_OSR_LSB +: 3];
    cfg_next.osr_value             = OSR_BASE << clock_next[CLK_OSR_LSB +: 3];
    cfg_next.power_mode_select     = clock_next[CLK_PWR_LSB +: 2];
    cfg_next.power_mode            = clock_next[CLK_PWR_LSB + 1] ? PWR_HR :
                                     (clock_next[CLK_PWR_LSB] ? PWR_LP : PWR_VLP);
    for (int i = 0; i < 4; i++) begin
      cfg_next.chan_gain_code[i] = gain_next[i*GAIN_STRIDE +: 3];
    end
    cfg_next.ready_source_select   = mode_next[MODE_SEL_LSB +: 2];
    cfg_next.ready_idle_tristate   = mode_next[MODE_HIZ_BIT];
    cfg_next.ready_pulse_format    = mode_next[MODE_FMT_BIT];
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_reg  <= MODE_RST;
      clock_reg <= CLOCK_RST;
      gain_reg  <= GAIN_RST;
      stat_reg  <= 6'h00;
      mask_reg  <= 6'h00;
      seen_reg  <= 6'h00;
      irq_reg   <= 1'b0;
      cfg_reg   <= '{chan_enable: 6'h3F, crystal_osc_off: 1'b0, external_reference_on: 1'b0,
                     oversampling_ratio: 3'h3, osr_value: 15'h0400, power_mode_select: 2'h2,
                     power_mode: PWR_HR, chan_gain_code: 12'h000, ready_source_select: 2'h0,
                     ready_idle_tristate: 1'b0, ready_pulse_format: 1'b0};
    end else begin
      mode_reg  <= mode_next;
      clock_reg <= clock_next;
      gain_reg  <= gain_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      seen_reg  <= seen_next;
      irq_reg   <= irq_next;
      cfg_reg   <= cfg_next;
    end
  end

  // pin follows the registered mode fields, one cycle behind a write
  adcc_ready_pin #(
    .PULSE_LEN (PULSE_LEN)
  ) u_pin (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .trig_in    (trig),
    .clr_in     (data_read_in),
    .hiz_in     (cfg_reg.ready_idle_tristate),
    .fmt_in     (cfg_reg.ready_pulse_format),
    .pin_out    (pin)
  );

  assign cfg_out                 = cfg_reg;
  assign irq_out                 = irq_reg;
  assign sample_ready_pin_out    = pin.o;
  assign sample_ready_pin_oe_out = pin.oe;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  clock_reset_a: assert property ($past(rst_in) |-> clock_reg == 16'h7F0E && gain_reg == 16'h0000)
    else $error("register reset value wrong");
  chan_enable_a: assert property ((wr_req && wr_idx == IDX_CLOCK && wr_strb == 4'hF)
    |=> cfg_out.chan_enable == $past(wr_data[13:8]))
    else $error("channel enable not taken");
  resv_zero_a: assert property ((rd_req && rd_idx == IDX_CLOCK) |=> s_axi_rdata_out[15:14] == 2'b00)
    else $error("reserved clock bits not zero");
  osr_value_a: assert property (cfg_out.osr_value == (15'h0080 << cfg_out.oversampling_ratio))
    else $error("oversampling value wrong");
  pwr_fold_a: assert property (cfg_out.power_mode_select[1] |-> cfg_out.power_mode == PWR_HR)
    else $error("power mode fold wrong");
  gain_codes_a: assert property ((wr_req && wr_idx == IDX_GAIN && wr_strb == 4'hF)
    |=> cfg_out.chan_gain_code == {$past(wr_data[14:12]), $past(wr_data[10:8]),
                                   $past(wr_data[6:4]), $past(wr_data[2:0])})
    else $error("gain codes not taken");
  lead_first_a: assert property ((cfg_out.ready_source_select[1] && ev != 6'h00 && seen_keep == 6'h00)
    |-> trig)
    else $error("leading source missed first channel");
  lag_wait_a: assert property ((cfg_out.ready_source_select == 2'h0 && ((seen_keep | ev | ~en) != 6'h3F))
    |-> !trig)
    else $error("lagging source fired early");
  xtal_ref_a: assert property ((wr_req && wr_idx == IDX_CLOCK && wr_strb[0])
    |=> cfg_out.crystal_osc_off == $past(wr_data[7]) && cfg_out.external_reference_on == $past(wr_data[6]))
    else $error("clock control bits not taken");
  irq_level_a: assert property (ev != 6'h00 && (ev & mask_reg) != 6'h00 |=> irq_out)
    else $error("interrupt missing");
  mode_fields_a: assert property ((wr_req && wr_idx == IDX_MODE && wr_strb[0])
    |=> cfg_out.ready_source_select == $past(wr_data[3:2]) && cfg_out.ready_idle_tristate == $past(wr_data[1])
        && cfg_out.ready_pulse_format == $past(wr_data[0]))
    else $error("ready mode fields not taken");
  osr_pwr_a: assert property ((wr_req && wr_idx == IDX_CLOCK && wr_strb[0])
    |=> cfg_out.oversampling_ratio == $past(wr_data[4:2]) && cfg_out.power_mode_select == $past(wr_data[1:0]))
    else $error("rate or power code not taken");
  or_fires_a: assert property ((cfg_out.ready_source_select == 2'h1 && (chan_event_in & cfg_out.chan_enable) != 6'h00)
    |-> trig)
    else $error("or source missed an enabled event");
  off_silent_a: assert property ((chan_event_in & cfg_out.chan_enable) == 6'h00 |-> !trig)
    else $error("disabled channel fired the ready pin");
  stat_clear_a: assert property ((rd_req && rd_idx == IDX_STAT && ev == 6'h00) |=> stat_reg == 6'h00)
    else $error("status not cleared by read");
  wr_refuse_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  rd_refuse_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  lag_cv: cover property (cfg_out.ready_source_select == 2'h0 && trig);
  stat_clr_cv: cover property (rd_req && rd_idx == IDX_STAT && ev != 6'h00);
  err_cv: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);

endmodule : adcc_cfg_regs

// file: adcc_chan_model.sv
`timescale 1ns/100ps
module adcc_chan_model
  import adcc_pkg::*;
(
  input  wire logic           sys_clk_in, // system clock
  input  wire logic           rst_in,     // sync reset
  input  wire logic [NCH-1:0] fire_in,    // channels to convert
  output logic      [NCH-1:0] event_out   // one-cycle new data pulses
);
  // registered so events never share an edge with the request
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) event_out <= '0;
    else        event_out <= fire_in;
  end
endmodule : adcc_chan_model

// file: tb.sv
`timescale 1ns/100ps
module tb;
  import adcc_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0, drd = 0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdt;
  logic [NCH-1:0] fire_r = '0, ev;
  logic awr, wrd, bv, arr, rv, po, poe, irq;
  logic [1:0] br, rr;
  adcc_cfg_t cfg;
  int fails = 0, compares = 0;
  logic [1:0] pm [4] = '{PWR_VLP, PWR_LP, PWR_HR, PWR_HR};
  always #4 clk = ~clk;
  adcc_chan_model mdl (.sys_clk_in(clk), .rst_in(rst), .fire_in(fire_r), .event_out(ev));
  adcc_cfg_regs #(.PULSE_LEN(4)) dut (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bq), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdt), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rq),
    .chan_event_in(ev), .data_read_in(drd), .cfg_out(cfg), .sample_ready_pin_out(po),
    .sample_ready_pin_oe_out(poe), .irq_out(irq));
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n >= 60) begin
      fails++;
      stop_test();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    bq <= 1'b0;
    guard(n);
    // let an edge pass so a following call may raise bready again
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rq <= 1'b0;
    guard(n);
    chk("rdata", e, rdt);
    chk("rresp", er, rr);
    @(posedge clk);
  endtask : rd
  task automatic fire(input logic [5:0] m, input logic eo, input logic eoe);
    fire_r <= m;
    @(posedge clk);
    fire_r <= '0;
    repeat (2) @(posedge clk);
    chk("pin", eo, po);
    chk("pin_oe", eoe, poe);
  endtask : fire
  task automatic clr;
    drd <= 1'b1;
    @(posedge clk);
    drd <= 1'b0;
    @(posedge clk);
  endtask : clr
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", e, irq);
  endtask : chk_irq
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin_oe", 1'b1, poe);
    // top two bits are stored but always read back as zero
    rd(8'h0C, 32'(CLOCK_RST & CLK_WMASK), RESP_OK);
    rd(8'h10, 32'(GAIN_RST), RESP_OK);
    rd(8'h3C, 32'h0, RESP_ERR);
    wr(8'h10, 32'h7531);
    rd(8'h10, 32'h7531, RESP_OK);
    chk("gain", {3'h7, 3'h5, 3'h3, 3'h1}, cfg.chan_gain_code);
    wr(8'h0C, 32'hFFDF);
    rd(8'h0C, 32'h3FDF, RESP_OK);
    chk("chan_en", 32'h3F, cfg.chan_enable);
    chk("xtal_ref", 2'h3, {cfg.crystal_osc_off, cfg.external_reference_on});
    for (int i = 0; i < 8; i++) begin
      wr(8'h0C, 32'h3F00 | 32'((i << 2) | (i & 3)));
      @(posedge clk);
      chk("osr", 32'(OSR_BASE) << i, cfg.osr_value);
      chk("pwr", pm[i & 3], cfg.power_mode);
    end
    wr(8'h24, 32'h3F);
    wr(8'h08, 32'h0);
    fire(6'h02, 1'b1, 1'b1);
    fire(6'h3D, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    chk("pin", 1'b0, po);
    clr();
    wr(8'h08, 32'h8);
    fire(6'h02, 1'b0, 1'b1);
    clr();
    wr(8'h08, 32'h4);
    fire(6'h20, 1'b0, 1'b1);
    clr();
    wr(8'h08, 32'hF);
    chk("pin_oe", 1'b0, poe);
    fire(6'h01, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk("pin", 1'b1, po);
    chk("pin_oe", 1'b0, poe);
    chk_irq(1'b1);
    wr(8'h24, 32'h0);
    chk_irq(1'b0);
    wr(8'h24, 32'h3F);
    chk_irq(1'b1);
    rd(8'h20, 32'h3F, RESP_OK);
    chk_irq(1'b0);
    // channel 0 off: its events must neither fire the pin nor set status
    wr(8'h0C, 32'h3E1F);
    chk("chan_en", 32'h3E, cfg.chan_enable);
    fire(6'h01, 1'b1, 1'b0);
    rd(8'h20, 32'h0, RESP_OK);
    stop_test();
  end
endmodule : tb
